// File: core/cdc_conv_core.sv
// register file and channel sequencer of the three-channel capacitance converter
//
// Contract
// (R1) loader writes 0x9C40 to channel 0 reference count at 0x08.
// (R2) loader writes 0x03E8 to channel 1 and 2 reference counts, 0x09 and 0x0A.
// (R3) settle counts at 0x10..0x12 hold 100; channel waits that many ticks first.
// (R4) fault setup bit 0 at 0x19 routes data-ready onto active-low interrupt pin; core also gates it with event_mask at 0x1C, reset 0.
// (R5) main control at 0x1A: active, low power, external reference, irq on, normal drive.
// (R6) channel scan at 0x1B: auto-scan channel 0, 1, 2 with 10MHz deglitch.
// (R7) loader writes 0x5000 to channel 0 drive current at 0x1E.
// (R8) loader writes 0x5800 to channel 1 and 2 drive currents, 0x1F and 0x20.
// (R9) main control written last, so conversions start after all channel settings.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module cdc_conv_core
#(
  parameter int CHANNELS = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire cdc_conv_pkg::reg_req_s bus_req,
  output logic [15:0] rdata,
  // reference clock and sensor oscillators
  input wire logic ref_clock_in,
  input wire logic [CHANNELS-1:0] sensor_in,
  // converter outputs
  output logic irq_out_n,
  output logic [1:0] active_channel,
  output logic converting,
  output logic [4:0] drive_level,
  output logic high_drive,
  output logic [2:0] deglitch_sel
);
  import cdc_conv_pkg::*;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [15:0] ref_count [CHANNELS];
  logic [15:0] settle_cycles [CHANNELS];
  logic [15:0] sensor_drive [CHANNELS];
  logic [15:0] fault_report_setup;
  logic [15:0] main_control;
  logic [15:0] channel_scan_setup;
  logic [CHANNELS-1:0] event_mask;
  logic [CHANNELS-1:0] event_status;
  logic [15:0] chan_data [CHANNELS];

  logic wr_en;
  logic rd_en;
  logic [7:0] addr;
  assign wr_en = bus_req.wr;
  assign rd_en = bus_req.rd;
  assign addr = bus_req.addr;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < CHANNELS; i++)
      begin
        ref_count[i] <= REF_COUNT_RST;
        settle_cycles[i] <= SETTLE_CYCLES_RST;
        sensor_drive[i] <= SENSOR_DRIVE_RST;
      end
      fault_report_setup <= FAULT_REPORT_RST;
      main_control <= MAIN_CONTROL_RST;
      channel_scan_setup <= SCAN_SETUP_RST;
      event_mask <= EVENT_MASK_RST;
    end
    else if (wr_en)
    begin
      unique case (addr)
        ADDR_CH0_REF_COUNT: ref_count[0] <= bus_req.wdata; // see (R1)
        ADDR_CH1_REF_COUNT: ref_count[1] <= bus_req.wdata; // see (R2)
        ADDR_CH2_REF_COUNT: ref_count[2] <= bus_req.wdata; // see (R2)
        ADDR_CH0_SETTLE_CYCLES: settle_cycles[0] <= bus_req.wdata; // see (R3)
        ADDR_CH1_SETTLE_CYCLES: settle_cycles[1] <= bus_req.wdata; // see (R3)
        ADDR_CH2_SETTLE_CYCLES: settle_cycles[2] <= bus_req.wdata; // see (R3)
        ADDR_FAULT_REPORT_SETUP: fault_report_setup <= bus_req.wdata; // see (R4)
        ADDR_MAIN_CONTROL: main_control <= bus_req.wdata; // see (R5)
        ADDR_CHANNEL_SCAN_SETUP: channel_scan_setup <= bus_req.wdata; // see (R6)
        ADDR_EVENT_MASK: event_mask <= bus_req.wdata[CHANNELS-1:0];
        ADDR_CH0_SENSOR_DRIVE: sensor_drive[0] <= bus_req.wdata; // see (R7)
        ADDR_CH1_SENSOR_DRIVE: sensor_drive[1] <= bus_req.wdata; // see (R8)
        ADDR_CH2_SENSOR_DRIVE: sensor_drive[2] <= bus_req.wdata; // see (R8)
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control field decode
  // ----------------------------------------------------------------
  logic sleep_mode;
  logic ref_external;
  logic irq_enabled;
  logic auto_scan;
  logic [1:0] last_channel;

  assign sleep_mode = main_control[CTRL_SLEEP_BIT]; // see (R5)
  assign ref_external = main_control[CTRL_REF_EXT_BIT]; // see (R5)
  assign irq_enabled = !main_control[CTRL_IRQ_DISABLE_BIT]; // see (R5)
  assign auto_scan = channel_scan_setup[SCAN_AUTO_BIT]; // see (R6)
  // sequence code 0 scans two channels, any other code scans all three
  assign last_channel = (channel_scan_setup[SCAN_SEQ_LSB +: 2] == SEQ_CH0_CH1) ?
                        2'h1 : LAST_CH_TWO; // see (R6)

  // ----------------------------------------------------------------
  // timebase: external reference edges or the core clock
  // ----------------------------------------------------------------
  logic ref_prev;
  logic tick;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ref_prev <= 1'b0;
    else
      ref_prev <= ref_clock_in;
  end

  // the pin is taken as synchronous, so one register is enough to find its rising edge
  assign tick = ref_external ? (ref_clock_in && !ref_prev) : 1'b1; // see (R5)

  // ----------------------------------------------------------------
  // sensor edge detect
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] sensor_prev;
  logic sensor_edge;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sensor_prev <= '0;
    else
      sensor_prev <= sensor_in;
  end

  assign sensor_edge = sensor_in[active_channel] && !sensor_prev[active_channel];

  // ----------------------------------------------------------------
  // channel sequencer
  // ----------------------------------------------------------------
  conv_state_e state;
  conv_state_e next_state;
  logic [15:0] tick_count;
  logic [15:0] edge_count;
  logic [15:0] settle_target;
  logic [15:0] ref_target;
  logic [1:0] next_channel;

  // a zero count still takes one tick
  assign settle_target = (settle_cycles[active_channel] == 16'h0000) ?
                         16'h0001 : settle_cycles[active_channel];
  assign ref_target = (ref_count[active_channel] == 16'h0000) ?
                      16'h0001 : ref_count[active_channel];

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (!sleep_mode)
          next_state = ST_SETTLE; // see (R9)
      ST_SETTLE:
        if (sleep_mode)
          next_state = ST_IDLE;
        else if (tick && (tick_count + 16'h0001 >= settle_target))
          next_state = ST_CONVERT; // see (R3)
      ST_CONVERT:
        if (sleep_mode)
          next_state = ST_IDLE;
        else if (tick && (tick_count + 16'h0001 >= ref_target))
          next_state = ST_DONE;
      ST_DONE:
        next_state = sleep_mode ? ST_IDLE : ST_SETTLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tick_count <= 16'h0000;
    else if (next_state != state)
      tick_count <= 16'h0000;
    else if (tick)
      tick_count <= tick_count + 16'h0001;
  end

  // sensor edges counted over the conversion window, saturating
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      edge_count <= 16'h0000;
    else if (state != ST_CONVERT)
      edge_count <= 16'h0000;
    else if (sensor_edge && edge_count != 16'hFFFF)
      edge_count <= edge_count + 16'h0001;
  end

  // wrap after the last channel of the selected sequence
  assign next_channel = (active_channel >= last_channel) ? 2'h0 : active_channel + 2'h1;

  // channel advance: 0 up to last_channel (2, or 1 for sequence code 0) then wrap in auto-scan, else stay on channel 0
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      active_channel <= 2'h0;
    else if (state == ST_IDLE || !auto_scan)
      active_channel <= 2'h0;
    else if (state == ST_DONE)
      active_channel <= next_channel; // see (R6)
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      for (int i = 0; i < CHANNELS; i++)
        chan_data[i] <= 16'h0000;
    else if (state == ST_DONE)
      chan_data[active_channel] <= edge_count;
  end

  // ----------------------------------------------------------------
  // data-ready events and interrupt
  // ----------------------------------------------------------------
  logic [CHANNELS-1:0] drdy_set;
  logic [CHANNELS-1:0] status_clr;

  always_comb
  begin
    drdy_set = '0;
    if (state == ST_DONE)
      drdy_set[active_channel] = 1'b1;
  end

  assign status_clr = (wr_en && addr == ADDR_EVENT_STATUS) ?
                      bus_req.wdata[CHANNELS-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      event_status <= '0;
    else
      event_status <= (event_status & ~status_clr) | drdy_set;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_out_n <= 1'b1;
    else
      irq_out_n <= !(fault_report_setup[FAULT_DRDY_TO_IRQ_BIT] && irq_enabled &&
                     |(event_status & event_mask)); // see (R4)
  end

  // ----------------------------------------------------------------
  // registered status outputs
  // ----------------------------------------------------------------
  // registered from next_state, so it is high exactly while converting
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      converting <= 1'b0;
    else
      converting <= (next_state == ST_CONVERT);
  end

  // one cycle behind a channel change
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      drive_level <= 5'h00;
    else
      drive_level <= sensor_drive[active_channel][DRIVE_LSB +: 5]; // see (R7)
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      high_drive <= 1'b0;
    else
      high_drive <= main_control[CTRL_HIGH_DRIVE_BIT]; // see (R5)
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      deglitch_sel <= 3'h0;
    else
      deglitch_sel <= channel_scan_setup[SCAN_DEGLITCH_LSB +: 3]; // see (R6)
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 16'h0000;
    else if (!rd_en)
      rdata <= 16'h0000;
    else
    begin
      unique case (addr)
        ADDR_CH0_DATA: rdata <= chan_data[0];
        ADDR_CH1_DATA: rdata <= chan_data[1];
        ADDR_CH2_DATA: rdata <= chan_data[2];
        ADDR_CH0_REF_COUNT: rdata <= ref_count[0];
        ADDR_CH1_REF_COUNT: rdata <= ref_count[1];
        ADDR_CH2_REF_COUNT: rdata <= ref_count[2];
        ADDR_CH0_SETTLE_CYCLES: rdata <= settle_cycles[0];
        ADDR_CH1_SETTLE_CYCLES: rdata <= settle_cycles[1];
        ADDR_CH2_SETTLE_CYCLES: rdata <= settle_cycles[2];
        ADDR_EVENT_STATUS: rdata <= {13'h0000, event_status};
        ADDR_FAULT_REPORT_SETUP: rdata <= fault_report_setup;
        ADDR_MAIN_CONTROL: rdata <= main_control;
        ADDR_CHANNEL_SCAN_SETUP: rdata <= channel_scan_setup;
        ADDR_EVENT_MASK: rdata <= {13'h0000, event_mask};
        ADDR_CH0_SENSOR_DRIVE: rdata <= sensor_drive[0];
        ADDR_CH1_SENSOR_DRIVE: rdata <= sensor_drive[1];
        ADDR_CH2_SENSOR_DRIVE: rdata <= sensor_drive[2];
        default: rdata <= 16'h0000;
      endcase
    end
  end

endmodule

// File: core/cdc_conv_pkg.sv
// shared constants, types and register map of the capacitance converter core
package cdc_conv_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CH0_DATA = 8'h00;
  localparam logic [7:0] ADDR_CH1_DATA = 8'h01;
  localparam logic [7:0] ADDR_CH2_DATA = 8'h02;
  localparam logic [7:0] ADDR_CH0_REF_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CH1_REF_COUNT = 8'h09;
  localparam logic [7:0] ADDR_CH2_REF_COUNT = 8'h0A;
  localparam logic [7:0] ADDR_CH0_SETTLE_CYCLES = 8'h10;
  localparam logic [7:0] ADDR_CH1_SETTLE_CYCLES = 8'h11;
  localparam logic [7:0] ADDR_CH2_SETTLE_CYCLES = 8'h12;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_FAULT_REPORT_SETUP = 8'h19;
  localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h1A;
  localparam logic [7:0] ADDR_CHANNEL_SCAN_SETUP = 8'h1B;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h1C;
  localparam logic [7:0] ADDR_CH0_SENSOR_DRIVE = 8'h1E;
  localparam logic [7:0] ADDR_CH1_SENSOR_DRIVE = 8'h1F;
  localparam logic [7:0] ADDR_CH2_SENSOR_DRIVE = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FAULT_DRDY_TO_IRQ_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 13;
  localparam int CTRL_LOW_POWER_ACT_BIT = 11;
  localparam int CTRL_REF_EXT_BIT = 9;
  localparam int CTRL_IRQ_DISABLE_BIT = 7;
  localparam int CTRL_HIGH_DRIVE_BIT = 6;
  localparam int SCAN_AUTO_BIT = 15;
  localparam int SCAN_SEQ_LSB = 13;
  localparam int SCAN_DEGLITCH_LSB = 0;
  localparam int DRIVE_LSB = 11;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] REF_COUNT_RST = 16'h0080;
  localparam logic [15:0] SETTLE_CYCLES_RST = 16'h0000;
  localparam logic [15:0] FAULT_REPORT_RST = 16'h0000;
  localparam logic [15:0] MAIN_CONTROL_RST = 16'h2801;
  localparam logic [15:0] SCAN_SETUP_RST = 16'h020F;
  localparam logic [15:0] SENSOR_DRIVE_RST = 16'h0000;
  localparam logic [2:0] EVENT_MASK_RST = 3'h0;
  localparam logic [1:0] SEQ_CH0_CH1 = 2'h0;
  localparam logic [1:0] LAST_CH_TWO = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_DONE = 4'b1000
  } conv_state_e;

endpackage

// File: testbench/cdc_conv_core_monitor.sv
// assertion checker bound to the converter core ports
`timescale 1ns/1ps

module cdc_conv_core_monitor
#(
  parameter int CHANNELS = 3
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire cdc_conv_pkg::reg_req_s bus_req,
  input wire logic [15:0] rdata,
  // pins
  input wire logic ref_clock_in,
  input wire logic [CHANNELS-1:0] sensor_in,
  // converter outputs
  input wire logic irq_out_n,
  input wire logic [1:0] active_channel,
  input wire logic converting,
  input wire logic [4:0] drive_level,
  input wire logic high_drive,
  input wire logic [2:0] deglitch_sel
);
  import cdc_conv_pkg::*;
  logic [1:0] up;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // cycles since reset release, held at 3, hides the reset-value load
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end
  a_rdata_idle: assert property (!bus_req.rd |=> rdata == 16'h0000)
    else $error("rdata outside read");
  a_scan_field: assert property (bus_req.wr && bus_req.addr == 8'h1B |->
    ##2 deglitch_sel == $past(bus_req.wdata[2:0], 2)) else $error("deglitch value");
  a_drive_select: assert property (bus_req.wr && bus_req.addr == 8'h1A |->
    ##2 high_drive == $past(bus_req.wdata[6], 2)) else $error("drive select");
  a_deglitch_cause: assert property (up == 2'h3 && $changed(deglitch_sel) |->
    $past(bus_req.wr, 2) && $past(bus_req.addr, 2) == 8'h1B) else $error("deglitch moved");
  a_irq_sticky: assert property (!irq_out_n && !bus_req.wr && !$past(bus_req.wr)
    |=> !irq_out_n) else $error("irq dropped");
  // a data-ready in the clearing cycle wins, so a conversion just ending is left out
  a_irq_clear: assert property (bus_req.wr && bus_req.addr == 8'h18 &&
    bus_req.wdata[2:0] == 3'h7 && !$past(converting) |-> ##2 irq_out_n)
    else $error("irq kept");
  a_sleep_abort: assert property (bus_req.wr && bus_req.addr == 8'h1A &&
    bus_req.wdata[13] |-> ##3 (!converting && active_channel == 2'h0) [*2])
    else $error("sleep ignored");
  a_scan_order: assert property ($changed(active_channel) |->
    active_channel == $past(active_channel) + 2'h1 || active_channel == 2'h0)
    else $error("channel order");
endmodule

bind cdc_conv_core cdc_conv_core_monitor #(.CHANNELS(CHANNELS)) cdc_conv_core_monitor_inst (
  .clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata), .ref_clock_in(ref_clock_in),
  .sensor_in(sensor_in), .irq_out_n(irq_out_n), .active_channel(active_channel),
  .converting(converting), .drive_level(drive_level), .high_drive(high_drive),
  .deglitch_sel(deglitch_sel));

// File: testbench/cfg_loader_model.sv
// host model that loads the converter setup once after start
`timescale 1ns/1ps

module cfg_loader_model
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic start,
  output logic done,
  // register port
  output cdc_conv_pkg::reg_req_s req
);
  import cdc_conv_pkg::*;
  // main control last, so scanning starts on a complete setup
  localparam logic [7:0] A [12] = '{8'h08, 8'h09, 8'h0A, 8'h10, 8'h11, 8'h12, 8'h19, 8'h1B,
    8'h1E, 8'h1F, 8'h20, 8'h1A};
  localparam logic [15:0] D [12] = '{16'h9C40, 16'h03E8, 16'h03E8, 16'h0064,
    16'h0064, 16'h0064, 16'h0001, 16'hA20D, 16'h5000,
    16'h5800, 16'h5800, 16'h1E01};
  logic run;
  logic [3:0] idx;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run <= 1'b0;
      idx <= 4'h0;
      done <= 1'b0;
    end
    else if (start)
    begin
      run <= 1'b1;
      idx <= 4'h0;
    end
    else if (run && idx == 4'hB)
    begin
      run <= 1'b0;
      done <= 1'b1;
    end
    else if (run)
      idx <= idx + 4'h1;
  end
  // released lines show the inverse of the last word
  assign req = '{addr: run ? A[idx] : ~A[idx], wdata: run ? D[idx] : ~D[idx], wr: run, rd: 1'b0};
endmodule

// File: testbench/test_cap_sensor_config_loader.sv
// testbench for the converter core with its start-up loader
`timescale 1ns/1ps

module test_cap_sensor_config_loader;
  import cdc_conv_pkg::*;
  localparam logic [7:0] EA [12] = '{8'h08, 8'h09, 8'h0A, 8'h10, 8'h11, 8'h12, 8'h19, 8'h1A,
    8'h1B, 8'h1E, 8'h1F, 8'h20};
  localparam logic [15:0] ED [12] = '{16'h9C40, 16'h03E8, 16'h03E8, 16'h0064, 16'h0064,
    16'h0064, 16'h0001, 16'h1E01, 16'hA20D, 16'h5000, 16'h5800, 16'h5800};
  logic clk, nrst, ld_sel, start, ld_done, early, ref_clk, converting, high_drive, irq_out_n;
  logic [2:0] sens;
  logic [2:0] deglitch_sel;
  logic [1:0] active_channel;
  logic [4:0] drive_level;
  logic [15:0] rdata;
  reg_req_s tb_req, ld_req, bus_req;
  int err_count, check_count, n;
  assign bus_req = ld_sel ? ld_req : tb_req;
  cdc_conv_core cdc_conv_core_inst (.clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
    .ref_clock_in(ref_clk), .sensor_in(sens), .irq_out_n(irq_out_n),
    .active_channel(active_channel), .converting(converting), .drive_level(drive_level),
    .high_drive(high_drive), .deglitch_sel(deglitch_sel));
  cfg_loader_model cfg_loader_model_inst (.clk(clk), .nrst(nrst), .start(start),
    .done(ld_done), .req(ld_req));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // far side: reference clock at half the core rate, free-running sensor counters
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      ref_clk <= 1'b0;
      sens <= 3'h0;
      early <= 1'b0;
    end
    else
    begin
      ref_clk <= ~ref_clk;
      sens <= sens + 3'h1;
      if (ld_sel && !ld_done && converting === 1'b1)
        early <= 1'b1;
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    tb_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    tb_req.wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    tb_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    tb_req.rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  function automatic logic hit(input int w);
    case (w)
      0: return converting === 1'b1;
      1: return irq_out_n === 1'b0;
      2: return active_channel === 2'h1;
      3: return active_channel === 2'h2;
      4: return active_channel === 2'h0;
      default: return ld_done === 1'b1;
    endcase
  endfunction
  // bounded wait, n counts the cycles taken
  task automatic await(input int w);
    n = 0;
    #1;
    while (!hit(w) && n < 500)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n < 500), 16'h0001);
  endtask
  initial
  begin
    #500000;
    err_count++;
    close_out();
  end
  initial
  begin
    nrst = 1'b0;
    tb_req = '0;
    ld_sel = 1'b0;
    start = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(8'h1A, MAIN_CONTROL_RST);
    rdc(8'h1B, SCAN_SETUP_RST);
    rdc(8'h10, SETTLE_CYCLES_RST);
    rdc(8'h30, 16'h0000);
    ld_sel <= 1'b1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    await(5);
    ld_sel <= 1'b0;
    chk({15'h0, early}, 16'h0000);
    for (int i = 0; i < 12; i++)
      rdc(EA[i], ED[i]);
    chk({15'h0, high_drive}, 16'h0000);
    chk({13'h0, deglitch_sel}, 16'h0005);
    wr(8'h1A, 16'h3E01);
    repeat (6) @(posedge clk);
    #1 chk({15'h0, converting}, 16'h0000);
    for (int i = 8; i < 11; i++)
      wr(8'(i), 16'h0002);
    wr(8'h1C, 16'h0007);
    wr(8'h18, 16'h0007);
    wr(8'h1A, 16'h1C01);
    await(0);
    chk(16'(n >= 99 && n <= 102), 16'h0001);
    await(1);
    await(2);
    repeat (2) @(posedge clk);
    #1 chk({11'h0, drive_level}, 16'h000B);
    await(3);
    await(4);
    repeat (2) @(posedge clk);
    #1 chk({11'h0, drive_level}, 16'h000A);
    rdc(8'h18, 16'h0007);
    wr(8'h1C, 16'h0000);
    @(posedge clk);
    #1 chk({15'h0, irq_out_n}, 16'h0001);
    wr(8'h1C, 16'h0007);
    wr(8'h1A, 16'h3E41);
    repeat (6) @(posedge clk);
    #1 chk({15'h0, irq_out_n}, 16'h0000);
    chk({15'h0, high_drive}, 16'h0001);
    wr(8'h18, 16'h0007);
    @(posedge clk);
    #1 chk({15'h0, irq_out_n}, 16'h0001);
    // two-channel sequence, interrupt disabled, ticks from the reference pin
    wr(8'h1B, 16'h800D);
    wr(8'h1A, 16'h1E81);
    await(2);
    chk(16'(n >= 203 && n <= 206), 16'h0001);
    await(4);
    chk({15'h0, irq_out_n}, 16'h0001);
    rdc(8'h18, 16'h0003);
    close_out();
  end
endmodule
